// File: core/power_mode_pkg.sv
package power_mode_pkg;
    localparam logic [7:0] PCTL_ADDR = 8'h87;
    localparam int BIT_HALT = 0;
    localparam int BIT_SLEEP = 1;
    localparam int BIT_FLAG0 = 2;
    localparam int BIT_FLAG1 = 3;
    localparam int BIT_BAUD = 7;
    localparam logic [7:0] PCTL_RESET = 8'h00;
    localparam logic [7:0] PCTL_WMASK = 8'h8f;
    localparam int RST_MACHINE_CYCLES = 2;
    localparam int OSC_PER_MACHINE = 12;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_IDLE = 3'b010,
        ST_DOWN = 3'b100
    } pmode_t;

    // Special function bus access from the CPU core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Pin drive decisions for strobes and ports
    typedef struct packed {
        logic ale;
        logic code_rd_n;
        logic p0_float;
        logic p2_from_latch;
    } pin_ctl_t;
endpackage : power_mode_pkg

// File: core/clock_gate_cell.sv
`timescale 1ns/1ns
`default_nettype none
// Latch-free gate enable: the enable is registered and qualifies the clock downstream
module clock_gate_cell
    import power_mode_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic run_i,
    output logic en_o
);
    typedef struct packed {
        logic en;
    } gate_state_t;
    gate_state_t st_r;
    gate_state_t st_nxt;

    // Next enable
    always_comb begin
        st_nxt = st_r;
        st_nxt.en = run_i;
    end

    // Register; enable high after reset so the clocks start running
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '{en: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign en_o = st_r.en;
endmodule : clock_gate_cell
`default_nettype wire

// File: core/cpu_power_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
// Power control register and Idle / Power Down sequencing
module cpu_power_mode_control
    import power_mode_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Special function register port from the CPU core
    input wire sfr_req_t sfr_i,
    input wire logic sfr_bit_op_i,
    input wire logic instr_done_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // Interrupt system
    input wire logic irq_pending_i,
    // External program memory strap and run-mode strobe levels
    input wire logic ext_code_i,
    input wire logic ale_run_i,
    input wire logic code_rd_run_i,
    // Clock enables
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    // Mode and serial control
    output logic baud_double_o,
    output logic idle_o,
    output logic power_down_o,
    // Pin control
    output logic address_strobe_out_o,
    output logic code_read_strobe_o,
    output logic p0_float_o,
    output logic p2_from_latch_o
);
    typedef struct packed {
        logic [7:0] pctl;
        pmode_t mode;
        logic pend_halt;
        logic pend_sleep;
        logic ext_s1;
        logic ext_s2;
        logic [7:0] rdata;
        pin_ctl_t pins;
    } pm_state_t;

    pm_state_t st_r;
    pm_state_t st_nxt;
    logic hit;
    logic byte_wr;
    logic cpu_run;

    // Byte-wide access at one address; bit operations ignored
    assign hit = sfr_i.addr == PCTL_ADDR;
    assign byte_wr = sfr_i.wr && hit && !sfr_bit_op_i;
    assign sfr_hit_o = hit && !sfr_bit_op_i;

    // Next state of the whole controller
    always_comb begin
        st_nxt = st_r;
        st_nxt.ext_s1 = ext_code_i;
        st_nxt.ext_s2 = st_r.ext_s1;
        // Bit operations never reach the register, reads included
        if (sfr_i.rd && hit && !sfr_bit_op_i) begin
            st_nxt.rdata = st_r.pctl;
        end
        unique case (st_r.mode)
            ST_RUN: begin
                if (byte_wr) begin
                    // Reserved bits 6..4 hold zero rather than garbage
                    st_nxt.pctl = sfr_i.wdata & PCTL_WMASK;
                    st_nxt.pend_sleep = sfr_i.wdata[BIT_SLEEP];
                    st_nxt.pend_halt = sfr_i.wdata[BIT_HALT];
                end
                // Mode changes at the first instruction end at or after the write
                if (instr_done_i || (byte_wr && instr_done_i)) begin
                    if (st_nxt.pend_sleep) begin
                        st_nxt.mode = ST_DOWN;
                    end else if (st_nxt.pend_halt) begin
                        st_nxt.mode = ST_IDLE;
                    end
                    st_nxt.pend_sleep = 1'b0;
                    st_nxt.pend_halt = 1'b0;
                end
            end
            ST_IDLE: begin
                // Wake clears halt bit; CPU resumes at next instruction
                if (irq_pending_i) begin
                    st_nxt.pctl[BIT_HALT] = 1'b0;
                    st_nxt.mode = ST_RUN;
                end
            end
            ST_DOWN: begin
                // Nothing but reset leaves; register contents kept
                st_nxt.mode = ST_DOWN;
            end
            default: begin
                st_nxt.mode = ST_RUN;
            end
        endcase
        // Pin states per mode
        st_nxt.pins.ale = ale_run_i;
        st_nxt.pins.code_rd_n = code_rd_run_i;
        st_nxt.pins.p0_float = 1'b0;
        st_nxt.pins.p2_from_latch = 1'b0;
        if (st_nxt.mode == ST_IDLE) begin
            st_nxt.pins.ale = 1'b1;
            st_nxt.pins.code_rd_n = 1'b1;
            st_nxt.pins.p0_float = st_r.ext_s2;
        end else if (st_nxt.mode == ST_DOWN) begin
            st_nxt.pins.ale = 1'b0;
            st_nxt.pins.code_rd_n = 1'b0;
            st_nxt.pins.p0_float = st_r.ext_s2;
            st_nxt.pins.p2_from_latch = 1'b1;
        end
    end

    // Synchronous reset restores the documented reset image
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r <= '{pctl: PCTL_RESET, mode: ST_RUN, pend_halt: 1'b0,
                      pend_sleep: 1'b0, ext_s1: 1'b0, ext_s2: 1'b0,
                      rdata: 8'h00, pins: '{ale: 1'b1, code_rd_n: 1'b1,
                      p0_float: 1'b0, p2_from_latch: 1'b0}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Only the CPU clock drops in Idle; CPU state freezes with it
    assign cpu_run = (st_nxt.mode == ST_RUN);

    clock_gate_cell u_cpu_gate (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .run_i(cpu_run),
        .en_o(cpu_clk_en_o)
    );

    // Peripherals and oscillator stop only in Power Down
    assign periph_clk_en_o = st_r.mode != ST_DOWN;
    assign osc_en_o = st_r.mode != ST_DOWN;

    assign sfr_rdata_o = st_r.rdata;
    assign baud_double_o = st_r.pctl[BIT_BAUD];
    assign idle_o = st_r.mode == ST_IDLE;
    assign power_down_o = st_r.mode == ST_DOWN;
    assign address_strobe_out_o = st_r.pins.ale;
    assign code_read_strobe_o = st_r.pins.code_rd_n;
    assign p0_float_o = st_r.pins.p0_float;
    assign p2_from_latch_o = st_r.pins.p2_from_latch;
endmodule : cpu_power_mode_control
`default_nettype wire

// File: bench/power_mode_props.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks of mode entry, wake and pin states
module power_mode_props
    import power_mode_pkg::*;
(
    // Clock, reset, requests
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire sfr_req_t sfr_i,
    input wire logic sfr_bit_op_i,
    input wire logic instr_done_i,
    input wire logic irq_pending_i,
    // Outputs watched
    input wire logic sfr_hit_o,
    input wire logic cpu_clk_en_o,
    input wire logic osc_en_o,
    input wire logic baud_double_o,
    input wire logic idle_o,
    input wire logic power_down_o,
    input wire logic address_strobe_out_o,
    input wire logic code_read_strobe_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Taken write in run mode only; low-power modes ignore writes
    logic wr_run;
    assign wr_run = sfr_i.wr && sfr_hit_o && instr_done_i && !idle_o && !power_down_o;
    AST_HIT: assert property (sfr_hit_o == (sfr_i.addr == 8'h87 && !sfr_bit_op_i))
        else $error("decode wrong");
    AST_HALT: assert property (wr_run && sfr_i.wdata[1:0] == 2'b01 |=> idle_o)
        else $error("no idle");
    AST_SLEEP: assert property (wr_run && sfr_i.wdata[1] |=> power_down_o && !idle_o)
        else $error("no power down");
    AST_BAUD: assert property (wr_run |=> baud_double_o == $past(sfr_i.wdata[7]))
        else $error("baud bit");
    AST_WAKE: assert property (idle_o && irq_pending_i |=> !idle_o && cpu_clk_en_o)
        else $error("no wake");
    AST_IDLE: assert property (idle_o |-> !cpu_clk_en_o && osc_en_o
        && address_strobe_out_o && code_read_strobe_o) else $error("idle state");
    AST_DOWN: assert property (power_down_o |-> !osc_en_o && !cpu_clk_en_o
        && !address_strobe_out_o && !code_read_strobe_o) else $error("down state");
    AST_HOLD: assert property (power_down_o |=> power_down_o)
        else $error("left power down");
endmodule : power_mode_props
bind cpu_power_mode_control power_mode_props i_power_mode_props (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .sfr_i(sfr_i), .sfr_bit_op_i(sfr_bit_op_i), .instr_done_i(instr_done_i),
    .irq_pending_i(irq_pending_i), .sfr_hit_o(sfr_hit_o), .cpu_clk_en_o(cpu_clk_en_o),
    .osc_en_o(osc_en_o), .baud_double_o(baud_double_o), .idle_o(idle_o),
    .power_down_o(power_down_o), .address_strobe_out_o(address_strobe_out_o),
    .code_read_strobe_o(code_read_strobe_o));
`default_nettype wire

// File: bench/irq_model.sv
`timescale 1ns/1ns
`default_nettype none
// Interrupt system stand-in: pends some cycles into Idle
module irq_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic idle_i,
    output logic irq_o
);
    logic [7:0] cnt_r;
    // Drops once Idle ends, as if the request were served
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !idle_i) begin
            cnt_r <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            irq_o <= (cnt_r >= 8'h04);
        end
    end
endmodule : irq_model
`default_nettype wire

// File: bench/cpu_power_mode_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module cpu_power_mode_control_tb;
    import power_mode_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sfr_req_t sfr = '0;
    logic bit_op = 1'b0, done = 1'b0, ext = 1'b0, irq;
    logic [7:0] rdata;
    logic hit, cpu_en, per_en, osc_en, baud, idle, down, ale, code_read_strobe, p0f, p2l;
    int n_mismatch = 0, num_checks = 0, cycles = 0;
    // Run strobes tied low so the Idle high strobe levels stand out
    cpu_power_mode_control i_cpu_power_mode_control (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .sfr_i(sfr), .sfr_bit_op_i(bit_op), .instr_done_i(done), .sfr_rdata_o(rdata),
        .sfr_hit_o(hit), .irq_pending_i(irq), .ext_code_i(ext), .ale_run_i(1'b0),
        .code_rd_run_i(1'b0), .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en),
        .osc_en_o(osc_en), .baud_double_o(baud), .idle_o(idle), .power_down_o(down),
        .address_strobe_out_o(ale), .code_read_strobe_o(code_read_strobe), .p0_float_o(p0f),
        .p2_from_latch_o(p2l));
    irq_model i_irq_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .idle_i(idle), .irq_o(irq));
    // Clock and hang guard
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 500) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // One byte access, held for exactly one taking edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic dn);
        @(posedge mclk_i);
        #10;
        sfr = '{wr: w, rd: !w, addr: a, wdata: d};
        done = dn;
        @(posedge mclk_i);
        #10;
        sfr = '0;
        done = 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] e);
        acc(1'b0, 8'h87, 8'h00, 1'b0);
        `CHK(rdata, e)
    endtask : rd
    // Main sequence; reset spans 12 clock cycles, a single machine cycle
    initial begin
        repeat (12) @(posedge mclk_i);
        #10;
        rst_n_i = 1'b1;
        rd(8'h00);
        acc(1'b1, 8'h87, 8'hfc, 1'b0);
        rd(8'h8c);
        `CHK(baud, 1'b1)
        bit_op = 1'b1;
        acc(1'b1, 8'h87, 8'h00, 1'b1);
        bit_op = 1'b0;
        acc(1'b1, 8'h88, 8'h01, 1'b1);
        rd(8'h8c);
        acc(1'b1, 8'h87, 8'h05, 1'b0);
        `CHK(idle, 1'b0)
        acc(1'b0, 8'h00, 8'h00, 1'b1);
        `CHK({idle, cpu_en, per_en, ale, code_read_strobe}, 5'h17)
        ext = 1'b1;
        repeat (3) @(posedge mclk_i);
        #10;
        `CHK({p0f, p2l}, 2'b10)
        // Look at idle only once it has settled after the edge
        for (int i = 0; i < 20 && idle !== 1'b0; i++) begin
            @(posedge mclk_i);
            #10;
        end
        rd(8'h04);
        acc(1'b1, 8'h87, 8'h0b, 1'b1);
        `CHK({down, idle, osc_en, ale, code_read_strobe, p0f, p2l}, 7'h43)
        `CHK(per_en, 1'b0)
        repeat (10) @(posedge mclk_i);
        #10;
        `CHK(down, 1'b1)
        rst_n_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        #10;
        rst_n_i = 1'b1;
        `CHK({down, osc_en, cpu_en}, 3'b011)
        rd(8'h00);
        results();
    end
endmodule : cpu_power_mode_control_tb
`default_nettype wire
